// >>> core/sram_pkg.sv
package sram_pkg;

	// Burst shape.
	localparam int BURST_LEN = 4;
	localparam int BEAT_W    = 2;
	localparam logic [BEAT_W-1:0] LAST_BEAT  = 2'h3;
	localparam logic [BEAT_W-1:0] FIRST_NEXT = 2'h1;

	// Read latency counted in rising edges of the output clock pair, or of the input clock pair when SINGLE_DOMAIN is set.
	localparam int LAT_W = 2;
	localparam logic [LAT_W-1:0] LAT_EDGES_PLL   = 2'h3;
	localparam logic [LAT_W-1:0] LAT_EDGES_NOPLL = 2'h2;
	localparam logic [LAT_W-1:0] LAT_LAST        = 2'h1;

	// Bit positions of the control pins in the sampled vector.
	localparam int SB_IN_P   = 0;
	localparam int SB_IN_N   = 1;
	localparam int SB_OUT_P  = 2;
	localparam int SB_OUT_N  = 3;
	localparam int SB_RSEL_N = 4;
	localparam int SB_WSEL_N = 5;
	localparam int SB_PLL    = 6;
	localparam int SB_SINGLE = 7;
	localparam int SB_CTRL_W = 8;

	// Reset values.
	localparam logic [SB_CTRL_W-1:0] SYNC_CTRL_RESET = 8'h30;
	localparam logic [3:0]           CLK_DLY_RESET   = 4'h0;
	localparam logic                 ECHO_RESET      = 1'b0;

	typedef enum logic {SLOT_READ, SLOT_WRITE} slot_t;
	typedef enum logic {WR_IDLE, WR_BURST} wr_state_t;
	typedef enum logic {ST_IDLE, ST_RUN} rd_state_t;

endpackage

// >>> core/sram_mem_if.sv
`timescale 1ns/1ps
interface sram_mem_if
	import sram_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int WORD_W = 18
);
	logic                              wr_en;
	logic [ADDR_W-1:0]                 wr_addr;
	logic [BURST_LEN-1:0][WORD_W-1:0]  wr_data;
	logic [ADDR_W-1:0]                 rd_addr;
	logic [BURST_LEN-1:0][WORD_W-1:0]  rd_data;
	logic                              fwd_valid;
	logic [ADDR_W-1:0]                 fwd_addr;
	logic [BURST_LEN-1:0]              fwd_mask;
	logic [BURST_LEN-1:0][WORD_W-1:0]  fwd_data;

	modport ctrl (
		output wr_en, wr_addr, wr_data, rd_addr,
		output fwd_valid, fwd_addr, fwd_mask, fwd_data,
		input  rd_data
	);
	modport mem (
		input  wr_en, wr_addr, wr_data, rd_addr,
		input  fwd_valid, fwd_addr, fwd_mask, fwd_data,
		output rd_data
	);
endinterface

// >>> core/sram_array.sv
`timescale 1ns/1ps
module sram_array
	import sram_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int WORD_W = 18
) (
	input  wire logic  clk,
	sram_mem_if.mem    bus
);
	localparam int DEPTH = 1 << ADDR_W;

	logic [BURST_LEN-1:0][WORD_W-1:0] store_reg [DEPTH];

	// Storage has no reset; its content is undefined until written.
	always_ff @(posedge clk) begin
		if (bus.wr_en) begin
			store_reg[bus.wr_addr] <= bus.wr_data;
		end
	end

	// Words of a write still being collected win over stored ones.
	genvar i;
	generate
		for (i = 0; i < BURST_LEN; i++) begin : g_word
			always_comb begin
				if (bus.fwd_valid && bus.fwd_addr == bus.rd_addr
				    && bus.fwd_mask[i]) begin
					bus.rd_data[i] = bus.fwd_data[i];
				end else begin
					bus.rd_data[i] = store_reg[bus.rd_addr][i];
				end
			end
		end
	endgenerate
endmodule // sram_array

// >>> core/sep_io_ddr_sram_burst4_port.sv
`timescale 1ns/1ps
module sep_io_ddr_sram_burst4_port
	import sram_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int WORD_W = 18
) (
	// System.
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	// Input clock pair and output clock pair.
	input  wire logic              IN_CLK_P,
	input  wire logic              IN_CLK_N,
	input  wire logic              OUT_CLK_P,
	input  wire logic              OUT_CLK_N,
	// Mode straps.
	input  wire logic              PLL_ENABLE_MODE_PIN,
	input  wire logic              SINGLE_DOMAIN,
	// Port selects, address and write data.
	input  wire logic              READ_PORT_SELECT_N,
	input  wire logic              WRITE_PORT_SELECT_N,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [WORD_W-1:0] WR_DATA,
	// Read data and echo clocks.
	output logic      [WORD_W-1:0] RD_DATA,
	output logic                   ECHO_CLOCK_PAIR_P,
	output logic                   ECHO_CLOCK_PAIR_N
);
	localparam int SYNC_W = SB_CTRL_W + ADDR_W + WORD_W;
	localparam logic [SYNC_W-1:0] SYNC_RESET =
		{{(ADDR_W + WORD_W){1'b0}}, SYNC_CTRL_RESET};

	// Input sampling: every pin passes two flip-flops.
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	logic [3:0]        clk_dly_reg;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			meta_reg    <= SYNC_RESET;
			sync_reg    <= SYNC_RESET;
			clk_dly_reg <= CLK_DLY_RESET;
		end else begin
			meta_reg    <= {WR_DATA, ADDR, SINGLE_DOMAIN,
			                PLL_ENABLE_MODE_PIN, WRITE_PORT_SELECT_N,
			                READ_PORT_SELECT_N, OUT_CLK_N, OUT_CLK_P,
			                IN_CLK_N, IN_CLK_P};
			sync_reg    <= meta_reg;
			clk_dly_reg <= sync_reg[3:0];
		end
	end

	logic              rsel_n;
	logic              wsel_n;
	logic              pll_on;
	logic              single;
	logic [ADDR_W-1:0] s_addr;
	logic [WORD_W-1:0] s_data;
	logic              in_rise_p;
	logic              in_rise_n;
	logic              in_edge;
	logic              out_edge;
	logic              echo_p_next;
	logic              echo_n_next;

	assign rsel_n = sync_reg[SB_RSEL_N];
	assign wsel_n = sync_reg[SB_WSEL_N];
	assign pll_on = sync_reg[SB_PLL];
	assign single = sync_reg[SB_SINGLE];
	assign s_addr = sync_reg[SB_CTRL_W +: ADDR_W];
	assign s_data = sync_reg[SB_CTRL_W + ADDR_W +: WORD_W];

	// Falling edges are never detected, so they cannot sample anything.
	always_comb begin
		in_rise_p = sync_reg[SB_IN_P] & ~clk_dly_reg[SB_IN_P];
		in_rise_n = sync_reg[SB_IN_N] & ~clk_dly_reg[SB_IN_N];
		in_edge   = in_rise_p | in_rise_n;
		if (single) begin
			out_edge    = in_edge;
			echo_p_next = sync_reg[SB_IN_P];
			echo_n_next = sync_reg[SB_IN_N];
		end else begin
			out_edge    = (sync_reg[SB_OUT_P] & ~clk_dly_reg[SB_OUT_P])
			            | (sync_reg[SB_OUT_N] & ~clk_dly_reg[SB_OUT_N]);
			echo_p_next = sync_reg[SB_OUT_P];
			echo_n_next = sync_reg[SB_OUT_N];
		end
	end

	sram_mem_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) mem_bus ();

	sram_array #(
		.ADDR_W (ADDR_W),
		.WORD_W (WORD_W)
	) u_array (
		.clk (CLK),
		.bus (mem_bus.mem)
	);

	// Address slot: read and write captures alternate.
	slot_t slot_reg;
	slot_t slot_next;

	always_comb begin
		slot_next = slot_reg;
		if (in_rise_p) begin
			slot_next = (slot_reg == SLOT_READ) ? SLOT_WRITE : SLOT_READ;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			slot_reg <= SLOT_READ;
		end else begin
			slot_reg <= slot_next;
		end
	end

	// Write port: collect four words, then commit the burst at once.
	wr_state_t                        wr_state_reg;
	wr_state_t                        wr_state_next;
	logic [ADDR_W-1:0]                wr_addr_reg;
	logic [ADDR_W-1:0]                wr_addr_next;
	logic [BEAT_W-1:0]                wr_beat_reg;
	logic [BEAT_W-1:0]                wr_beat_next;
	logic [BURST_LEN-1:0][WORD_W-1:0] wr_buf_reg;
	logic [BURST_LEN-1:0][WORD_W-1:0] wr_buf_next;
	logic [BURST_LEN-1:0]             wr_mask_reg;
	logic [BURST_LEN-1:0]             wr_mask_next;
	logic                             commit_reg;
	logic                             commit_next;

	always_comb begin
		wr_state_next = wr_state_reg;
		wr_addr_next  = wr_addr_reg;
		wr_beat_next  = wr_beat_reg;
		wr_buf_next   = wr_buf_reg;
		wr_mask_next  = wr_mask_reg;
		commit_next   = 1'b0;
		if (commit_reg) begin
			wr_mask_next = '0;
		end
		unique case (wr_state_reg)
			WR_IDLE: begin
				if (in_rise_p && slot_reg == SLOT_WRITE
				    && !wsel_n) begin
					wr_state_next  = WR_BURST;
					wr_addr_next   = s_addr;
					wr_buf_next[0] = s_data;
					wr_mask_next   = {{(BURST_LEN-1){1'b0}}, 1'b1};
					wr_beat_next   = FIRST_NEXT;
				end
			end
			WR_BURST: begin
				if (in_edge) begin
					wr_buf_next[wr_beat_reg]  = s_data;
					wr_mask_next[wr_beat_reg] = 1'b1;
					wr_beat_next = BEAT_W'(wr_beat_reg + 1'b1);
					if (wr_beat_reg == LAST_BEAT) begin
						wr_state_next = WR_IDLE;
						commit_next   = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_state_reg <= WR_IDLE;
			wr_addr_reg  <= '0;
			wr_beat_reg  <= '0;
			wr_buf_reg   <= '0;
			wr_mask_reg  <= '0;
			commit_reg   <= 1'b0;
		end else begin
			wr_state_reg <= wr_state_next;
			wr_addr_reg  <= wr_addr_next;
			wr_beat_reg  <= wr_beat_next;
			wr_buf_reg   <= wr_buf_next;
			wr_mask_reg  <= wr_mask_next;
			commit_reg   <= commit_next;
		end
	end

	// The committed burst is still forwarded in its commit cycle, so no
	// read falls into a gap between buffer and array.
	assign mem_bus.wr_en     = commit_reg;
	assign mem_bus.wr_addr   = wr_addr_reg;
	assign mem_bus.wr_data   = wr_buf_reg;
	assign mem_bus.fwd_valid = (wr_state_reg == WR_BURST) | commit_reg;
	assign mem_bus.fwd_addr  = wr_addr_reg;
	assign mem_bus.fwd_mask  = wr_mask_reg;
	assign mem_bus.fwd_data  = wr_buf_reg;

	// Read port: a pending address waits out the latency, then streams.
	// An output rise seen after the capture cycle counts as a latency
	// edge, so the output pair must rise together with the input pair.
	logic              pend_valid_reg;
	logic              pend_valid_next;
	logic [ADDR_W-1:0] pend_addr_reg;
	logic [ADDR_W-1:0] pend_addr_next;
	logic [LAT_W-1:0]  pend_cnt_reg;
	logic [LAT_W-1:0]  pend_cnt_next;
	logic              rd_capture;
	logic              pend_fire;

	always_comb begin
		pend_valid_next = pend_valid_reg;
		pend_addr_next  = pend_addr_reg;
		pend_cnt_next   = pend_cnt_reg;
		rd_capture = in_rise_p && slot_reg == SLOT_READ
		             && !rsel_n;
		pend_fire  = pend_valid_reg && out_edge
		             && pend_cnt_reg == LAT_LAST;
		if (rd_capture) begin
			pend_valid_next = 1'b1;
			pend_addr_next  = s_addr;
			pend_cnt_next   = pll_on ? LAT_EDGES_PLL
			                         : LAT_EDGES_NOPLL;
		end else if (pend_valid_reg && out_edge) begin
			if (pend_cnt_reg == LAT_LAST) begin
				pend_valid_next = 1'b0;
			end else begin
				pend_cnt_next = LAT_W'(pend_cnt_reg - 1'b1);
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pend_valid_reg <= 1'b0;
			pend_addr_reg  <= '0;
			pend_cnt_reg   <= '0;
		end else begin
			pend_valid_reg <= pend_valid_next;
			pend_addr_reg  <= pend_addr_next;
			pend_cnt_reg   <= pend_cnt_next;
		end
	end

	rd_state_t         rd_state_reg;
	rd_state_t         rd_state_next;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic [ADDR_W-1:0] rd_addr_next;
	logic [BEAT_W-1:0] rd_beat_reg;
	logic [BEAT_W-1:0] rd_beat_next;
	logic [WORD_W-1:0] rd_data_reg;
	logic [WORD_W-1:0] rd_data_next;
	logic              echo_p_reg;
	logic              echo_n_reg;

	// Words are fetched beat by beat, so a later write is seen at once.
	assign mem_bus.rd_addr = (rd_state_reg == ST_RUN) ? rd_addr_reg
	                                                  : pend_addr_reg;

	// The read side never looks at write state, so both ports overlap.
	always_comb begin
		rd_state_next = rd_state_reg;
		rd_addr_next  = rd_addr_reg;
		rd_beat_next  = rd_beat_reg;
		rd_data_next  = rd_data_reg;
		unique case (rd_state_reg)
			ST_IDLE: begin
				if (pend_fire) begin
					rd_data_next  = mem_bus.rd_data[0];
					rd_addr_next  = pend_addr_reg;
					rd_beat_next  = FIRST_NEXT;
					rd_state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (out_edge) begin
					rd_data_next = mem_bus.rd_data[rd_beat_reg];
					rd_beat_next = BEAT_W'(rd_beat_reg + 1'b1);
					if (rd_beat_reg == LAST_BEAT) begin
						rd_state_next = ST_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_state_reg <= ST_IDLE;
			rd_addr_reg  <= '0;
			rd_beat_reg  <= '0;
			rd_data_reg  <= '0;
			echo_p_reg   <= ECHO_RESET;
			echo_n_reg   <= ECHO_RESET;
		end else begin
			rd_state_reg <= rd_state_next;
			rd_addr_reg  <= rd_addr_next;
			rd_beat_reg  <= rd_beat_next;
			rd_data_reg  <= rd_data_next;
			echo_p_reg   <= echo_p_next;
			echo_n_reg   <= echo_n_next;
		end
	end

	assign RD_DATA           = rd_data_reg;
	assign ECHO_CLOCK_PAIR_P = echo_p_reg;
	assign ECHO_CLOCK_PAIR_N = echo_n_reg;
endmodule // sep_io_ddr_sram_burst4_port

// >>> dv/sram_port_sva.sv
`timescale 1ns/1ps
module sram_port_sva
	import sram_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int WORD_W = 18
) (
	// System.
	input wire logic              CLK,
	input wire logic              ARST_N,
	// Link pins.
	input wire logic              IN_CLK_P,
	input wire logic              OUT_CLK_P,
	input wire logic              OUT_CLK_N,
	input wire logic              SINGLE_DOMAIN,
	input wire logic              READ_PORT_SELECT_N,
	// Read side.
	input wire logic [WORD_W-1:0] RD_DATA,
	input wire logic              ECHO_CLOCK_PAIR_P,
	input wire logic              ECHO_CLOCK_PAIR_N
);
	logic [6:0] quiet_reg;
	logic [6:0] quiet_next;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	// Long enough that no burst can still be in flight.
	always_comb begin
		quiet_next = quiet_reg;
		if (!READ_PORT_SELECT_N)
			quiet_next = 7'h00;
		else if (quiet_reg != 7'h7F)
			quiet_next = quiet_reg + 7'h01;
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			quiet_reg <= 7'h00;
		else
			quiet_reg <= quiet_next;
	end

	reset_word_a: assert property (
		$rose(ARST_N) |-> RD_DATA == '0)
		else $error("read word not cleared by reset");
	data_echo_a: assert property (
		$changed(RD_DATA) |->
		$rose(ECHO_CLOCK_PAIR_P) || $rose(ECHO_CLOCK_PAIR_N))
		else $error("read word moved without an echo edge");
	echo_quiet_a: assert property (
		(!SINGLE_DOMAIN && $stable(OUT_CLK_P) && $stable(OUT_CLK_N))[*6]
		|-> $stable(ECHO_CLOCK_PAIR_P) && $stable(ECHO_CLOCK_PAIR_N))
		else $error("echo moved with output clocks still");
	echo_p_a: assert property (
		!SINGLE_DOMAIN && $rose(OUT_CLK_P) |-> ##[1:5] $rose(ECHO_CLOCK_PAIR_P))
		else $error("true echo missed an output clock rise");
	echo_n_a: assert property (
		!SINGLE_DOMAIN && $rose(OUT_CLK_N) |-> ##[1:5] $rose(ECHO_CLOCK_PAIR_N))
		else $error("inverse echo missed an output clock rise");
	single_echo_a: assert property (
		SINGLE_DOMAIN && $rose(IN_CLK_P) |-> ##[1:5] $rose(ECHO_CLOCK_PAIR_P))
		else $error("echo not taken from input clocks");
	read_quiet_a: assert property (
		quiet_reg >= 7'h20 |-> $stable(RD_DATA))
		else $error("read word moved with no read selected");
	fall_quiet_a: assert property (
		$fell(OUT_CLK_N) && $stable(OUT_CLK_P) |=> $stable(RD_DATA)[*6])
		else $error("read word moved on a falling clock");
endmodule // sram_port_sva

bind sep_io_ddr_sram_burst4_port sram_port_sva #(
	.ADDR_W(ADDR_W),
	.WORD_W(WORD_W)
) sram_port_sva_i (
	.CLK               (CLK),
	.ARST_N            (ARST_N),
	.IN_CLK_P          (IN_CLK_P),
	.OUT_CLK_P         (OUT_CLK_P),
	.OUT_CLK_N         (OUT_CLK_N),
	.SINGLE_DOMAIN     (SINGLE_DOMAIN),
	.READ_PORT_SELECT_N(READ_PORT_SELECT_N),
	.RD_DATA           (RD_DATA),
	.ECHO_CLOCK_PAIR_P (ECHO_CLOCK_PAIR_P),
	.ECHO_CLOCK_PAIR_N (ECHO_CLOCK_PAIR_N)
);

// >>> dv/sram_host_model.sv
`timescale 1ns/1ps
module sram_host_model #(
	parameter int ADDR_W = 6,
	parameter int WORD_W = 18
) (
	// System clock.
	input  wire logic              clk,
	// Link pins towards the memory.
	output logic                   in_p,
	output logic                   in_n,
	output logic                   out_p,
	output logic                   out_n,
	output logic                   rsel_n,
	output logic                   wsel_n,
	output logic      [ADDR_W-1:0] addr,
	output logic      [WORD_W-1:0] wdata,
	// Read words coming back.
	input  wire logic [WORD_W-1:0] rdata
);
	logic              idle;
	int                hidx;
	logic [WORD_W-1:0] got [0:23];

	initial begin
		in_p   = 1'b0;
		in_n   = 1'b0;
		out_p  = 1'b0;
		out_n  = 1'b0;
		rsel_n = 1'b1;
		wsel_n = 1'b1;
		addr   = '0;
		wdata  = '0;
		idle   = 1'b1;
		hidx   = 0;
	end

	// Released lines swing every cycle, so a stale value never passes.
	always @(posedge clk) begin
		if (idle) begin
			addr  <= ~addr;
			wdata <= ~wdata;
		end
	end

	// Pins settle two cycles before the clock edge and hold two after.
	task automatic half(input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d, input logic r_n, input logic w_n);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		rsel_n <= r_n;
		wsel_n <= w_n;
		@(negedge clk);
		got[hidx] = rdata;
		repeat (2) @(posedge clk);
		// The output pair rises with the input pair, so the output rise
		// that matches a capture is not counted as a latency edge.
		in_p  <= ~in_p;
		in_n  <= in_p;
		out_p <= ~in_p;
		out_n <= in_p;
		@(posedge clk);
		hidx = hidx + 1;
	endtask

	task automatic start();
		hidx = 0;
		idle <= 1'b0;
		@(posedge clk);
	endtask

	// Frames end after whole read and write slot pairs, clocks then stop.
	task automatic park();
		repeat (8) @(posedge clk);
		in_n   <= 1'b0;
		rsel_n <= 1'b1;
		wsel_n <= 1'b1;
		idle   <= 1'b1;
		@(posedge clk);
		out_n <= 1'b0;
	endtask
endmodule // sram_host_model

// >>> dv/sep_io_ddr_sram_burst4_port_bench.sv
`timescale 1ns/1ps
module sep_io_ddr_sram_burst4_port_bench
	import sram_pkg::*;
;
	localparam int ADDR_W = 6;
	localparam int WORD_W = 18;

	logic              clk;
	logic              arst_n;
	logic              pll_mode;
	logic              single_dom;
	logic              in_p;
	logic              in_n;
	logic              out_p;
	logic              out_n;
	logic              rsel_n;
	logic              wsel_n;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] wdata;
	logic [WORD_W-1:0] rd_data;
	int                fail_count;
	int                num_checks;
	logic [ADDR_W-1:0] ta [0:23];
	logic [WORD_W-1:0] td [0:23];
	logic              trn [0:23];
	logic              twn [0:23];

	sep_io_ddr_sram_burst4_port #(.ADDR_W(ADDR_W), .WORD_W(WORD_W))
	sep_io_ddr_sram_burst4_port_i (
		.CLK                (clk),
		.ARST_N             (arst_n),
		.IN_CLK_P           (in_p),
		.IN_CLK_N           (in_n),
		.OUT_CLK_P          (out_p),
		.OUT_CLK_N          (out_n),
		.PLL_ENABLE_MODE_PIN(pll_mode),
		.SINGLE_DOMAIN      (single_dom),
		.READ_PORT_SELECT_N (rsel_n),
		.WRITE_PORT_SELECT_N(wsel_n),
		.ADDR               (addr),
		.WR_DATA            (wdata),
		.RD_DATA            (rd_data),
		.ECHO_CLOCK_PAIR_P  (),
		.ECHO_CLOCK_PAIR_N  ()
	);
	sram_host_model #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) sram_host_model_i (
		.clk   (clk),
		.in_p  (in_p),
		.in_n  (in_n),
		.out_p (out_p),
		.out_n (out_n),
		.rsel_n(rsel_n),
		.wsel_n(wsel_n),
		.addr  (addr),
		.wdata (wdata),
		.rdata (rd_data)
	);

	always #25 clk = ~clk;

	task automatic chk(input string what, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic clr();
		for (int h = 0; h < 24; h++) begin
			ta[h]  = '0;
			td[h]  = '0;
			trn[h] = 1'b1;
			twn[h] = 1'b1;
		end
	endtask

	task automatic wr(input int h, input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] b);
		ta[h]  = a;
		twn[h] = 1'b0;
		for (int k = 0; k < BURST_LEN; k++)
			td[h+k] = b + WORD_W'(k);
	endtask

	task automatic rd(input int h, input logic [ADDR_W-1:0] a);
		ta[h]  = a;
		trn[h] = 1'b0;
	endtask

	// Word k of a burst lands in sample slot s+k.
	task automatic burst(input string what, input int s,
		input logic [WORD_W-1:0] b);
		for (int k = 0; k < BURST_LEN; k++)
			chk(what, sram_host_model_i.got[s+k], b + WORD_W'(k));
	endtask

	task automatic run();
		sram_host_model_i.start();
		for (int h = 0; h < 24; h++)
			sram_host_model_i.half(ta[h], td[h], trn[h], twn[h]);
		sram_host_model_i.park();
	endtask

	// A read meets the next write's words in flight, then a refused write.
	task automatic sc_pll_rw();
		@(posedge clk);
		pll_mode   <= 1'b1;
		single_dom <= 1'b0;
		clr();
		wr(2, 6'h05, 18'h01000);
		rd(4, 6'h05);
		wr(6, 6'h05, 18'h02000);
		rd(8, 6'h05);
		wr(10, 6'h05, 18'h3F000);
		twn[10] = 1'b1;
		rd(12, 6'h05);
		run();
		chk("lead", sram_host_model_i.got[8], 18'h00000);
		burst("first", 9, 18'h02000);
		burst("second", 13, 18'h02000);
		burst("refused write", 17, 18'h02000);
		chk("stand", sram_host_model_i.got[23], 18'h02003);
	endtask

	// Short latency with the output registers on the input clocks.
	task automatic sc_nopll_single();
		@(posedge clk);
		pll_mode   <= 1'b0;
		single_dom <= 1'b1;
		clr();
		wr(2, 6'h3F, 18'h2A5A0);
		rd(4, 6'h3F);
		rd(8, 6'h05);
		run();
		chk("lead", sram_host_model_i.got[7], 18'h02003);
		burst("short", 8, 18'h2A5A0);
		burst("kept", 12, 18'h02000);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end

	initial begin
		clk        = 1'b0;
		arst_n     = 1'b0;
		pll_mode   = 1'b1;
		single_dom = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("reset word", rd_data, 18'h00000);
		sc_pll_rw();
		sc_nopll_single();
		finish_test();
	end
endmodule // sep_io_ddr_sram_burst4_port_bench
